/* File: core/urt_pkg.sv */
package urt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] URT_ADDR_MODE     = 16'hFFB4;
  localparam logic [15:0] URT_ADDR_COUNT    = 16'hFFB5;
  localparam logic [15:0] URT_ADDR_CLK_STOP = 16'hFFFA;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] URT_MODE_RST     = 8'h18;
  localparam logic [7:0] URT_COUNT_RST    = 8'h00;
  localparam logic [7:0] URT_RELOAD_RST   = 8'h00;
  localparam logic [7:0] URT_CLK_STOP_RST = 8'hFF;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam logic [1:0] URT_MODE_RSVD     = 2'h3;
  localparam logic [7:0] URT_STOP_RO_MASK  = 8'hC0;
  localparam int         URT_STOP_BIT      = 1;
  localparam logic [7:0] URT_CNT_MAX       = 8'hFF;
  localparam logic [7:0] URT_CNT_MIN       = 8'h00;
  localparam logic [7:0] URT_CNT_ONE       = 8'h01;

  // ----------------------------------------------------------------
  // count sources: codes below URT_SEL_SUB index the prescaler taps
  // ----------------------------------------------------------------
  localparam int         URT_TAPS    = 6;
  localparam logic [2:0] URT_SEL_SUB = 3'h6;
  localparam logic [2:0] URT_SEL_EVT = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int URT_CLK_PERIOD_NS = 25;
  // worst count-cycle error of the resynchronised subclock
  localparam int URT_SYNC_ERR_NS   = 25;
  localparam int URT_SYNC_ERR_CYC  = (URT_SYNC_ERR_NS + URT_CLK_PERIOD_NS - 1) / URT_CLK_PERIOD_NS;

  typedef struct packed {
    logic       reload_select;
    logic       hw_updown_select;
    logic       sw_down_select;
    logic [1:0] rsvd;
    logic [2:0] clock_select;
  } urt_mode_s;

endpackage

/* File: core/urt_sync_edge.sv */
`timescale 1ns/1ps
module urt_sync_edge
  import urt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output wire logic rise_pulse,
  output wire logic fall_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ----------------------------------------------------------------
  // two-stage synchroniser plus edge history
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // one-cycle pulses; latency costs up to one period of count error
  assign rise_pulse = sync_ff & ~last_ff;
  assign fall_pulse = ~sync_ff & last_ff;

endmodule // urt_sync_edge

/* File: core/urt_src_sel.sv */
`timescale 1ns/1ps
module urt_src_sel
  import urt_pkg::*;
(
  input  wire logic [URT_TAPS-1:0] presc_tap,
  input  wire logic                sub_tick,
  input  wire logic                evt_tick,
  input  wire logic [2:0]          clock_select,
  output wire logic                count_en
);

  wire logic tap_sel;
  wire logic use_tap;

  // ----------------------------------------------------------------
  // source select
  // ----------------------------------------------------------------
  assign use_tap  = clock_select < URT_SEL_SUB;
  assign tap_sel  = use_tap ? presc_tap[clock_select] : 1'b0;
  assign count_en = use_tap ? tap_sel :
                    (clock_select == URT_SEL_SUB) ? sub_tick : evt_tick;

endmodule // urt_src_sel

/* File: core/urt_timer8.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module urt_timer8
  import urt_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [URT_TAPS-1:0] presc_tap,
  input  wire logic                sub_clk_div4,
  input  wire logic                event_input_pin,
  input  wire logic                event_edge_select,
  input  wire logic                up_down_pin,
  input  wire logic                timer_c_irq_enable,
  input  wire logic                irq_flag_clr,
  output logic                     timer_c_irq_flag,
  output wire logic                timer_c_irq
);

  urt_mode_s  mode_ff;
  urt_mode_s  nxt_mode;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [7:0] reload_ff;
  logic [7:0] clk_stop_ff;
  logic [7:0] nxt_clk_stop;
  logic       flag_ff;
  logic       nxt_flag;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  wire logic       hit_mode;
  wire logic       hit_count;
  wire logic       hit_stop;
  wire logic       wr_mode;
  wire logic       wr_reload;
  wire logic       wr_stop;
  wire logic [7:0] rd_mux;
  wire logic       sub_rise;
  wire logic       evt_rise;
  wire logic       evt_fall;
  wire logic       evt_tick;
  wire logic       count_en;
  wire logic       run;
  wire logic       step;
  wire logic       dir_down;
  wire logic       at_limit;
  wire logic [7:0] wrap_val;
  wire logic [7:0] stepped;
  wire logic       roll;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign hit_mode  = reg_addr == URT_ADDR_MODE;
  assign hit_count = reg_addr == URT_ADDR_COUNT;
  assign hit_stop  = reg_addr == URT_ADDR_CLK_STOP;
  assign wr_mode   = reg_wr & hit_mode;
  assign wr_reload = reg_wr & hit_count;
  assign wr_stop   = reg_wr & hit_stop;

  assign nxt_mode = wr_mode ?
                    urt_mode_s'({reg_wdata[7:5], URT_MODE_RSVD, reg_wdata[2:0]}) :
                    mode_ff;

  assign nxt_clk_stop = wr_stop ? (reg_wdata | URT_STOP_RO_MASK) : clk_stop_ff;

  // read path samples the mode, counter and clock-stop registers
  assign rd_mux = hit_mode  ? mode_ff :
                  hit_count ? count_ff :
                  hit_stop  ? clk_stop_ff : 8'h00;

  assign nxt_rdata = reg_rd ? rd_mux : 8'h00;

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  // subclock resynchronised
  urt_sync_edge u_sub_sync (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .async_in   (sub_clk_div4),
    .rise_pulse (sub_rise),
    .fall_pulse ()
  );

  urt_sync_edge u_evt_sync (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .async_in   (event_input_pin),
    .rise_pulse (evt_rise),
    .fall_pulse (evt_fall)
  );

  assign evt_tick = event_edge_select ? evt_rise : evt_fall;

  urt_src_sel u_src_sel (
    .presc_tap    (presc_tap),
    .sub_tick     (sub_rise),
    .evt_tick     (evt_tick),
    .clock_select (mode_ff.clock_select),
    .count_en     (count_en)
  );

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // standby halts counting
  assign run  = clk_stop_ff[URT_STOP_BIT];
  assign step = run & count_en;

  assign dir_down = mode_ff.hw_updown_select ? up_down_pin : mode_ff.sw_down_select;

  assign at_limit = dir_down ? (count_ff == URT_CNT_MIN) : (count_ff == URT_CNT_MAX);
  assign roll     = step & at_limit;

  assign wrap_val = mode_ff.reload_select ? reload_ff :
                    dir_down ? URT_CNT_MAX : URT_CNT_MIN;

  assign stepped = dir_down ? count_ff - URT_CNT_ONE : count_ff + URT_CNT_ONE;

  // reload write beats a same-cycle tick
  assign nxt_count = wr_reload ? reg_wdata :
                     roll      ? wrap_val :
                     step      ? stepped : count_ff;

  assign nxt_flag = roll | (flag_ff & ~irq_flag_clr);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // reset values
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff     <= urt_mode_s'(URT_MODE_RST);
      count_ff    <= URT_COUNT_RST;
      reload_ff   <= URT_RELOAD_RST;
      clk_stop_ff <= URT_CLK_STOP_RST;
      flag_ff     <= 1'b0;
      rdata_ff    <= 8'h00;
    end else begin
      mode_ff     <= nxt_mode;
      count_ff    <= nxt_count;
      reload_ff   <= wr_reload ? reg_wdata : reload_ff;
      clk_stop_ff <= nxt_clk_stop;
      flag_ff     <= nxt_flag;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign timer_c_irq_flag = flag_ff;
  assign timer_c_irq      = flag_ff & timer_c_irq_enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rsvd_read_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && hit_mode) |=> (reg_rdata[4:3] == URT_MODE_RSVD)
  ) else $error("reserved mode bits not read as one");

  chk_count_read: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && hit_count) |=> (reg_rdata == $past(count_ff))
  ) else $error("count read returned wrong value");

  chk_reload_load: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_reload |=> (count_ff == $past(reg_wdata)) && (reload_ff == $past(reg_wdata))
  ) else $error("reload write did not load counter");

  chk_step_by_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (step && !at_limit && !wr_reload) |=>
      (count_ff == ($past(dir_down) ? $past(count_ff) - 8'h01 : $past(count_ff) + 8'h01))
  ) else $error("counter did not step by one");

  chk_hw_direction: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (mode_ff.hw_updown_select && up_down_pin && step && !at_limit && !wr_reload)
      |=> (count_ff == $past(count_ff) - 8'h01)
  ) else $error("pin high did not count down");

  chk_interval_wrap: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (roll && !mode_ff.reload_select && !wr_reload) |=>
      (count_ff == ($past(dir_down) ? URT_CNT_MAX : URT_CNT_MIN))
  ) else $error("interval wrap value wrong");

  chk_auto_reload: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (roll && mode_ff.reload_select && !wr_reload) |=> (count_ff == $past(reload_ff))
  ) else $error("auto-reload value not loaded");

  chk_flag_set: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    roll |=> timer_c_irq_flag
  ) else $error("flag not set on roll");

  chk_flag_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (timer_c_irq_flag && !irq_flag_clr) |=> timer_c_irq_flag
  ) else $error("flag dropped without clear");

  chk_irq_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    timer_c_irq |-> (timer_c_irq_flag && timer_c_irq_enable)
  ) else $error("request without flag and enable");

  chk_standby_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!clk_stop_ff[URT_STOP_BIT] && !wr_reload) |=> $stable(count_ff)
  ) else $error("counter moved in standby");

  chk_no_tick_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!count_en && !wr_reload) [*2] |=> $stable(count_ff)
  ) else $error("counter moved without tick");

  chk_mode_select: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_mode |=> (mode_ff.reload_select == $past(reg_wdata[7]))
  ) else $error("reload select not written");

endmodule // urt_timer8

/* File: sim/urt_pins_model.sv */
`timescale 1ns/1ps
module urt_pins_model (
  input  wire logic sys_clk,
  input  wire logic ev_req,
  input  wire logic dir_req,
  input  wire logic sub_req,
  output logic      event_input_pin,
  output logic      up_down_pin,
  output logic      sub_clk_div4
);
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // pin functions enabled, shared irq off
  always_ff @(posedge sys_clk) begin
    event_input_pin <= ev_req;
    up_down_pin     <= dir_req;
  end
  // subclock level moves only when asked, like a slow free source
  always_ff @(posedge sys_clk) begin
    sub_clk_div4 <= sub_req;
  end
endmodule // urt_pins_model

/* File: sim/urt_timer8_tb_top.sv */
`timescale 1ns/1ps
module urt_timer8_tb_top;
  import urt_pkg::*;
  logic                sys_clk, rst_b, reg_wr, reg_rd, ev_req, dir_req, evt_edge, irq_en, flg_clr, sub_req;
  logic                rd_seen = 1'b0;
  logic [15:0]         reg_addr;
  logic [7:0]          reg_wdata, reg_rdata, v;
  logic [URT_TAPS-1:0] presc_tap;
  logic                ev_pin, ud_pin, sub_clk, flag, irq;
  logic [7:0]          exp_q[$];
  logic [31:0]         rng;
  int                  errors, n_tests;

  urt_timer8 i_urt_timer8 (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .presc_tap(presc_tap), .sub_clk_div4(sub_clk),
    .event_input_pin(ev_pin), .event_edge_select(evt_edge), .up_down_pin(ud_pin),
    .timer_c_irq_enable(irq_en), .irq_flag_clr(flg_clr), .timer_c_irq_flag(flag), .timer_c_irq(irq));
  urt_pins_model i_urt_pins_model (.sys_clk(sys_clk), .ev_req(ev_req), .dir_req(dir_req), .sub_req(sub_req),
    .event_input_pin(ev_pin), .up_down_pin(ud_pin), .sub_clk_div4(sub_clk));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic tick(int s, int n);
    repeat (n) begin
      @(posedge sys_clk);
      presc_tap <= URT_TAPS'(1) << s;
      @(posedge sys_clk);
      presc_tap <= '0;
    end
    #1;
  endtask
  task automatic clr();
    @(posedge sys_clk);
    flg_clr <= 1'b1;
    @(posedge sys_clk);
    flg_clr <= 1'b0;
    #1;
    chk1("flag", 1'b0, flag);
  endtask
  task automatic evt(logic lvl);
    ev_req <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic sub(logic lvl);
    sub_req <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // read data watcher: data stand one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0)
      chk8("rdata", exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
  end

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end

  initial begin
    {rst_b, reg_wr, reg_rd, ev_req, dir_req, evt_edge, irq_en, flg_clr, sub_req} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    presc_tap = '0;
    rng = 32'hB41C8892;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(URT_ADDR_MODE, URT_MODE_RST);
    rd(URT_ADDR_COUNT, 8'h00);
    rd(URT_ADDR_CLK_STOP, URT_CLK_STOP_RST);
    rd(16'hFFB6, 8'h00);
    tick(0, 3);
    rd(URT_ADDR_COUNT, 8'h03);
    $display("test reset done");
    for (int s = 0; s < URT_TAPS; s++) begin
      wr(URT_ADDR_MODE, 8'(s));
      rd(URT_ADDR_MODE, 8'h18 | 8'(s));
      rng = xs(rng);
      v = rng[7:0];
      wr(URT_ADDR_COUNT, v);
      tick((s + 1) % URT_TAPS, 2);
      tick(s, 3);
      rd(URT_ADDR_COUNT, v + 8'h03);
    end
    $display("test sources done");
    wr(URT_ADDR_MODE, 8'h05);
    clr();
    wr(URT_ADDR_COUNT, 8'hFF);
    tick(5, 1);
    chk1("flag", 1'b1, flag);
    chk1("irq", 1'b0, irq);
    @(posedge sys_clk);
    irq_en <= 1'b1;
    #1 chk1("irq", 1'b1, irq);
    rd(URT_ADDR_COUNT, 8'h00);
    clr();
    wr(URT_ADDR_MODE, 8'h25);
    wr(URT_ADDR_COUNT, 8'h01);
    tick(5, 2);
    chk1("flag", 1'b1, flag);
    rd(URT_ADDR_COUNT, 8'hFF);
    $display("test interval done");
    clr();
    wr(URT_ADDR_MODE, 8'h85);
    wr(URT_ADDR_COUNT, 8'hFE);
    tick(5, 3);
    chk1("flag", 1'b1, flag);
    rd(URT_ADDR_COUNT, 8'hFF);
    wr(URT_ADDR_MODE, 8'hA5);
    wr(URT_ADDR_COUNT, 8'h01);
    tick(5, 2);
    rd(URT_ADDR_COUNT, 8'h01);
    // clear held high across a roll: the set must win
    flg_clr <= 1'b1;
    tick(5, 2);
    chk1("flag", 1'b1, flag);
    flg_clr <= 1'b0;
    $display("test reload done");
    wr(URT_ADDR_MODE, 8'h65);
    dir_req <= 1'b1;
    wr(URT_ADDR_COUNT, 8'h10);
    tick(5, 2);
    dir_req <= 1'b0;
    tick(5, 1);
    rd(URT_ADDR_COUNT, 8'h0F);
    wr(URT_ADDR_CLK_STOP, 8'h3D);
    rd(URT_ADDR_CLK_STOP, 8'hFD);
    wr(URT_ADDR_COUNT, 8'h40);
    tick(5, 3);
    rd(URT_ADDR_COUNT, 8'h40);
    wr(URT_ADDR_CLK_STOP, 8'hFF);
    tick(5, 1);
    rd(URT_ADDR_COUNT, 8'h41);
    $display("test direction and standby done");
    wr(URT_ADDR_MODE, 8'h07);
    evt_edge <= 1'b1;
    wr(URT_ADDR_COUNT, 8'h20);
    evt(1'b1);
    evt(1'b0);
    rd(URT_ADDR_COUNT, 8'h21);
    evt_edge <= 1'b0;
    evt(1'b1);
    evt(1'b0);
    rd(URT_ADDR_COUNT, 8'h22);
    $display("test events done");
    wr(URT_ADDR_MODE, 8'h06);
    wr(URT_ADDR_COUNT, 8'h30);
    evt(1'b1);
    evt(1'b0);
    sub(1'b1);
    sub(1'b0);
    sub(1'b1);
    sub(1'b0);
    rd(URT_ADDR_COUNT, 8'h32);
    $display("test subclock done");
    wr(URT_ADDR_CLK_STOP, 8'h3D);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk1("flag", 1'b0, flag);
    rd(URT_ADDR_MODE, URT_MODE_RST);
    rd(URT_ADDR_COUNT, URT_COUNT_RST);
    rd(URT_ADDR_CLK_STOP, URT_CLK_STOP_RST);
    wr(URT_ADDR_MODE, 8'hA5);
    tick(5, 1);
    rd(URT_ADDR_COUNT, URT_RELOAD_RST);
    $display("test second reset done");
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule // urt_timer8_tb_top
